// ==== tof_pkg.sv ====
// Constants, register map and carrier types for the threshold flag block
// Behaviour
// - Overtemperature flag sets whenever the temperature reading lies below the threshold.
// - Each threshold code step raises the trip level by about 3.04 mV.
// - The temperature reading spans 0 V to 1.55 V full scale.
// - Usable trip level runs from 9.12 mV (code 3) to 760 mV (code 250).
// - The overtemperature flag has a 16 mV hysteresis band.
// - Switch register bits 7:6 choose the accurate switch flag threshold.
// - Field value 00 means 0 mV; 01 and 10 are reserved.
package tof_pkg;

  // Printed register indexes; byte address is four times the index
  localparam logic [7:0] IDX_TEMP_READING = 8'h1A;
  localparam logic [7:0] IDX_OTP_TRIP = 8'h2F;
  localparam logic [7:0] IDX_SWITCH_CTRL = 8'h30;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
  localparam logic [7:0] IDX_LIVE_FLAGS = 8'h42;
  localparam int ADDR_W = 12;

  // Reset values
  localparam logic [7:0] RST_OTP_TRIP = 8'h32;
  localparam logic [7:0] RST_SWITCH_CTRL = 8'h00;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // Field positions
  localparam int SW_THR_HI = 7;
  localparam int SW_THR_LO = 6;
  localparam int IRQ_OT_SET = 0;
  localparam int IRQ_OT_CLR = 1;
  localparam int IRQ_SW_SET = 2;
  localparam int IRQ_W = 3;

  // Analog scaling, in microvolts; readings scaled by ADC step count
  localparam int ADC_FS_UV = 1550000;
  localparam int ADC_STEPS = 256;
  localparam int OTP_LSB_UV = 3040;
  localparam int OTP_HYST_UV = 16000;
  localparam logic [7:0] OTP_CODE_MIN = 8'h03;
  localparam logic [7:0] OTP_CODE_MAX = 8'hFA;
  localparam logic [31:0] HYST_SCALED = 32'(OTP_HYST_UV * ADC_STEPS);
  localparam logic [31:0] FS_SCALED = 32'(ADC_FS_UV * ADC_STEPS);

  // Accurate switch threshold codes, in sense ADC counts (0 mV)
  localparam logic [1:0] SW_THR_0MV = 2'h0;
  localparam logic signed [11:0] SW_THR_0MV_CNT = 12'sh000;

  // APB request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } tof_apb_req_s;

  // Sampled sense inputs
  typedef struct packed {
    logic temp_valid;
    logic [7:0] temp_code;
    logic cs_valid;
    logic signed [11:0] cs_diff;
  } tof_sense_s;

endpackage

// ==== tof_threshold_flags.sv ====
// Overtemperature and output-switch threshold flags with APB registers
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module tof_threshold_flags import tof_pkg::*; (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // APB slave
  input wire tof_apb_req_s apb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Sense inputs
  input wire tof_sense_s sense_i,
  // Flags and interrupt
  output logic overtemp_flag_o,
  output logic output_isolation_switch_flag_o,
  output logic irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0] otp_trip;
  logic [7:0] switch_ctrl;
  logic [7:0] temp_reading;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic ot_flag;
  logic sw_flag;

  //////////////////////////////////////////////////////////////////////////
  // APB decode
  logic access;
  logic wr_now;
  logic [7:0] idx;
  logic mapped;
  logic [31:0] next_rdata;

  // One wait state: pready rises on the second access cycle
  assign access = apb_i.psel & apb_i.penable;
  assign wr_now = access & pready_o & apb_i.pwrite;
  assign idx = apb_i.paddr[9:2];

  // Register read mux, upper bits read as zero
  always_comb begin
    mapped = 1'b1;
    next_rdata = 32'h0000_0000;
    if (apb_i.paddr[ADDR_W-1:10] != 2'h0 || apb_i.paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else begin
      unique case (idx)
        IDX_TEMP_READING: next_rdata = {24'h000000, temp_reading};
        IDX_OTP_TRIP: next_rdata = {24'h000000, otp_trip};
        IDX_SWITCH_CTRL: next_rdata = {24'h000000, switch_ctrl};
        IDX_IRQ_STATUS: next_rdata = {29'h0, irq_status};
        IDX_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        IDX_LIVE_FLAGS: next_rdata = {30'h0, sw_flag, ot_flag};
        default: mapped = 1'b0;
      endcase
    end
  end

  // Bus answer; read data taken at the edge that raises pready, one edge before the one that completes
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= access & ~pready_o;
      pslverr_o <= access & ~pready_o & ~mapped;
      if (access & ~pready_o & ~apb_i.pwrite) begin
        prdata_o <= next_rdata;
      end
    end
  end

  // Writable configuration registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      otp_trip <= RST_OTP_TRIP;
      switch_ctrl <= RST_SWITCH_CTRL;
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_now && mapped) begin
      if (idx == IDX_OTP_TRIP) begin
        otp_trip <= apb_i.pwdata[7:0];
      end
      if (idx == IDX_SWITCH_CTRL) begin
        switch_ctrl <= apb_i.pwdata[7:0];
      end
      if (idx == IDX_IRQ_MASK) begin
        irq_mask <= apb_i.pwdata[IRQ_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Overtemperature comparison
  logic [7:0] eff_code;
  logic [31:0] rd_scaled;
  logic [31:0] thr_scaled;
  logic [31:0] clr_scaled;
  logic below_thr;
  logic above_clr;

  // Codes outside the usable band are clamped to its ends
  always_comb begin
    if (otp_trip < OTP_CODE_MIN) begin
      eff_code = OTP_CODE_MIN;
    end else if (otp_trip > OTP_CODE_MAX) begin
      eff_code = OTP_CODE_MAX;
    end else begin
      eff_code = otp_trip;
    end
  end

  // Both sides scaled by the step count to stay in integers
  assign rd_scaled = 32'(sense_i.temp_code) * 32'(ADC_FS_UV);
  assign thr_scaled = 32'(eff_code) * 32'(OTP_LSB_UV * ADC_STEPS);
  assign clr_scaled = thr_scaled + HYST_SCALED;
  assign below_thr = rd_scaled < thr_scaled;
  assign above_clr = rd_scaled > clr_scaled;

  // Latest reading kept for software
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      temp_reading <= 8'h00;
    end else if (sense_i.temp_valid) begin
      temp_reading <= sense_i.temp_code;
    end
  end

  // Flag with hysteresis; readings between holds the flag
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ot_flag <= 1'b0;
    end else if (sense_i.temp_valid) begin
      if (below_thr) begin
        ot_flag <= 1'b1;
      end else if (above_clr) begin
        ot_flag <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Accurate output-switch flag
  logic signed [11:0] sw_thr;

  // Reserved codes fall back to 0 mV rather than an undefined level
  always_comb begin
    unique case (switch_ctrl[SW_THR_HI:SW_THR_LO])
      SW_THR_0MV: sw_thr = SW_THR_0MV_CNT;
      default: sw_thr = SW_THR_0MV_CNT;
    endcase
  end

  // Flag follows each new current-sense sample
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sw_flag <= 1'b0;
    end else if (sense_i.cs_valid) begin
      sw_flag <= sense_i.cs_diff > sw_thr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] w1c;
  logic ot_prev;
  logic sw_prev;

  // Edge memory for event detection
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ot_prev <= 1'b0;
      sw_prev <= 1'b0;
    end else begin
      ot_prev <= ot_flag;
      sw_prev <= sw_flag;
    end
  end

  assign irq_event[IRQ_OT_SET] = ot_flag & ~ot_prev;
  assign irq_event[IRQ_OT_CLR] = ~ot_flag & ot_prev;
  assign irq_event[IRQ_SW_SET] = sw_flag & ~sw_prev;
  assign w1c = (wr_now && mapped && idx == IDX_IRQ_STATUS) ?
    apb_i.pwdata[IRQ_W-1:0] : '0;

  // Sticky status bits, a new event beats a clear
  generate
    for (genvar b = 0; b < IRQ_W; b++) begin : g_sticky
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          irq_status[b] <= 1'b0;
        end else if (irq_event[b]) begin
          irq_status[b] <= 1'b1;
        end else if (w1c[b]) begin
          irq_status[b] <= 1'b0;
        end
      end
    end
  endgenerate

  // Registered outputs
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
      overtemp_flag_o <= 1'b0;
      output_isolation_switch_flag_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
      overtemp_flag_o <= ot_flag;
      output_isolation_switch_flag_o <= sw_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_ot_set_below: assert property (
    sense_i.temp_valid && below_thr |=> ot_flag ##1 overtemp_flag_o)
    else $error("overtemp flag not set below threshold");

  a_trip_step: assert property (
    (otp_trip >= OTP_CODE_MIN && otp_trip <= OTP_CODE_MAX) |->
    thr_scaled == 32'(otp_trip) * 32'(OTP_LSB_UV) * 32'(ADC_STEPS))
    else $error("trip level step wrong");

  a_reading_span: assert property (
    rd_scaled <= FS_SCALED && (sense_i.temp_code != 8'h00 ||
    rd_scaled == 32'h0))
    else $error("reading outside full scale");

  a_trip_range: assert property (
    eff_code >= OTP_CODE_MIN && eff_code <= OTP_CODE_MAX)
    else $error("trip code outside usable band");

  a_hyst_hold: assert property (
    ot_flag && sense_i.temp_valid && !above_clr |=> ot_flag)
    else $error("flag dropped inside hysteresis band");

  a_sw_field: assert property (
    sense_i.cs_valid && sense_i.cs_diff > 12'sh000 |=> sw_flag
    ##1 output_isolation_switch_flag_o)
    else $error("switch flag not set above threshold");

  a_sw_zero: assert property (
    sense_i.cs_valid && sense_i.cs_diff <= 12'sh000 |=> !sw_flag)
    else $error("switch flag set at or below 0 mV");

  a_ot_clear: assert property (
    $fell(ot_flag) |-> $past(sense_i.temp_valid) && $past(above_clr))
    else $error("overtemp flag cleared without hysteresis");

  a_irq_level: assert property (
    |(irq_status & irq_mask) |=> irq_o)
    else $error("interrupt not raised");

  a_irq_low: assert property (
    !(|(irq_status & irq_mask)) |=> !irq_o)
    else $error("interrupt raised with nothing pending");

  // Status bits: a new event must win over a clear in the same cycle
  a_sticky_set: assert property (
    irq_event[IRQ_SW_SET] |=> irq_status[IRQ_SW_SET])
    else $error("switch event not held in status");

  a_sticky_clear: assert property (
    w1c[IRQ_OT_SET] && !irq_event[IRQ_OT_SET] |=> !irq_status[IRQ_OT_SET])
    else $error("overtemp status not cleared by write");

  // Bus timing: exactly one wait state, answer lasts one cycle
  a_ready_wait: assert property (
    access && !pready_o |=> pready_o)
    else $error("ready missing after one wait state");

  a_ready_pulse: assert property (
    pready_o |=> !pready_o)
    else $error("ready held for two cycles");

  a_err_ready: assert property (
    pslverr_o |-> pready_o)
    else $error("error without ready");

  a_err_unmapped: assert property (
    access && !pready_o && !mapped |=> pslverr_o)
    else $error("unmapped access not flagged");

  // Read data must stand until the next read, masters may sample late
  a_rdata_hold: assert property (
    !(access && !pready_o && !apb_i.pwrite) |=> $stable(prdata_o))
    else $error("read data changed without a read");

  // Register and sample capture
  a_trip_write: assert property (
    wr_now && mapped && idx == IDX_OTP_TRIP |=>
    32'(otp_trip) == ($past(apb_i.pwdata) & 32'h0000_00FF))
    else $error("trip code write lost");

  a_switch_write: assert property (
    wr_now && mapped && idx == IDX_SWITCH_CTRL |=>
    32'(switch_ctrl) == ($past(apb_i.pwdata) & 32'h0000_00FF))
    else $error("switch control write lost");

  a_mask_write: assert property (
    wr_now && mapped && idx == IDX_IRQ_MASK |=>
    32'(irq_mask) == ($past(apb_i.pwdata) & 32'h0000_0007))
    else $error("mask write lost");

  a_reading_take: assert property (
    sense_i.temp_valid |=> temp_reading == $past(sense_i.temp_code))
    else $error("temperature reading not captured");

  a_reading_hold: assert property (
    !sense_i.temp_valid |=> $stable(temp_reading))
    else $error("temperature reading changed without a sample");

  // Flags move only on a fresh sample; outputs trail by one register
  a_ot_idle: assert property (
    !sense_i.temp_valid |=> $stable(ot_flag))
    else $error("overtemp flag moved without a sample");

  a_ot_release: assert property (
    ot_flag && sense_i.temp_valid && above_clr |=> !ot_flag)
    else $error("overtemp flag held above release level");

  a_sw_hold: assert property (
    !sense_i.cs_valid |=> $stable(sw_flag))
    else $error("switch flag moved without a sample");

  a_ot_out: assert property (
    1'b1 |=> overtemp_flag_o == $past(ot_flag))
    else $error("overtemp output does not follow flag");

  a_sw_out: assert property (
    1'b1 |=> output_isolation_switch_flag_o == $past(sw_flag))
    else $error("switch output does not follow flag");

  c_ot_trip: cover property ($rose(overtemp_flag_o));
  c_ot_release: cover property ($fell(overtemp_flag_o));
  c_sw_flag: cover property ($rose(output_isolation_switch_flag_o));
  c_irq: cover property ($rose(irq_o));
  c_status_clear: cover property (w1c != '0);

endmodule

// ==== tof_sense_model.sv ====
// Model of the sense converters that feed the threshold flag block
`timescale 1ns/10ps
module tof_sense_model import tof_pkg::*; (
  // Clock
  input wire logic clk_sys_i,
  // Sample requests
  input wire logic temp_go_i,
  input wire logic [7:0] temp_code_i,
  input wire logic cs_go_i,
  input wire logic signed [11:0] cs_diff_i,
  // Sense bus
  output tof_sense_s sense_o = '0
);
  // One valid beat per request; data churns between beats so a stale
  // value is never mistaken for a fresh sample
  always @(posedge clk_sys_i) begin
    sense_o.temp_valid <= temp_go_i;
    sense_o.temp_code <= temp_go_i ? temp_code_i : ~sense_o.temp_code;
    sense_o.cs_valid <= cs_go_i;
    sense_o.cs_diff <= cs_go_i ? cs_diff_i : ~sense_o.cs_diff;
  end
endmodule

// ==== tb.sv ====
// Self-checking testbench for the threshold flag block
`timescale 1ns/10ps
module tb import tof_pkg::*; ;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  tof_apb_req_s apb = '0;
  tof_sense_s sense;
  logic [31:0] prdata, rd;
  logic pready, pslverr, ot_flag, sw_flag, irq, err, exp_ot = 1'b0;
  logic temp_go = 1'b0, cs_go = 1'b0;
  logic [7:0] temp_code = 8'h00, tc = 8'h32, c;
  logic [7:0] corner [4] = '{8'h00, 8'h03, 8'hFA, 8'hFF};
  logic signed [11:0] cs_diff = 12'sh000;
  int bad_count = 0, checks = 0;
  integer seed = 32'h1099c61f;

  ////////////////////////////////////////////////////////////////////////
  // Clock, design and sense model
  initial forever #4 clk_sys_i = ~clk_sys_i;
  tof_threshold_flags dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .apb_i(apb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .sense_i(sense), .overtemp_flag_o(ot_flag),
    .output_isolation_switch_flag_o(sw_flag), .irq_o(irq));
  tof_sense_model model (.clk_sys_i(clk_sys_i), .temp_go_i(temp_go),
    .temp_code_i(temp_code), .cs_go_i(cs_go), .cs_diff_i(cs_diff),
    .sense_o(sense));

  ////////////////////////////////////////////////////////////////////////
  // Checking and closing
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Flag with hysteresis, all in microvolts times 256 to stay integral
  function automatic logic next_ot(input logic o, input logic [7:0] c, t);
    int r, th;
    th = (t < 3) ? 3 : (t > 250) ? 250 : int'(t);
    th = th * 3040 * 256;
    r = int'(c) * 1550000;
    if (r < th) return 1'b1;
    if (r > th + 16000 * 256) return 1'b0;
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus and sense drivers; all entered right after a rising edge
  task automatic apb_x(input logic wr, input logic [7:0] idx,
                       input logic [31:0] d);
    apb.psel <= 1'b1;
    apb.pwrite <= wr;
    apb.paddr <= {2'b00, idx, 2'b00};
    apb.pwdata <= d;
    @(posedge clk_sys_i);
    apb.penable <= 1'b1;
    // Wait as long as it takes; only the watchdog ends a hung access
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    // Extra edge so the next setup never lands in this time step
    @(posedge clk_sys_i);
  endtask
  task automatic temp_send(input logic [7:0] v);
    temp_code <= v;
    temp_go <= 1'b1;
    @(posedge clk_sys_i);
    temp_go <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    exp_ot = next_ot(exp_ot, v, tc);
  endtask
  task automatic cs_send(input logic signed [11:0] v);
    cs_diff <= v;
    cs_go <= 1'b1;
    @(posedge clk_sys_i);
    cs_go <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog, well past the six hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    apb_x(0, IDX_OTP_TRIP, 0);
    chk("trip reset", rd, 32'(RST_OTP_TRIP));
    apb_x(0, IDX_SWITCH_CTRL, 0);
    chk("switch reset", rd, 32'(RST_SWITCH_CTRL));
    // Corner and random trip codes, readings alternately random and near the trip point
    for (int i = 0; i < 64; i++) begin
      if (i % 8 == 0) begin
        tc = (i < 32) ? corner[i/8] : 8'($random(seed));
        apb_x(1, IDX_OTP_TRIP, {24'h0, tc});
      end
      c = (i % 2) ? 8'(tc / 2 + $random(seed) % 5) : 8'($random(seed));
      temp_send(c);
      chk("overtemp", ot_flag, exp_ot);
      if (i % 8 == 7) begin
        apb_x(0, IDX_TEMP_READING, 0);
        chk("reading", rd, {24'h0, c});
      end
    end
    // Every switch field value against differences round zero
    for (int f = 0; f < 4; f++) begin
      apb_x(1, IDX_SWITCH_CTRL, 32'(f) << 6);
      for (int d = -1; d < 2; d++) begin
        cs_send(12'(d));
        chk("switch flag", sw_flag, 32'(d > 0));
      end
    end
    // Interrupt: raise, mask, clear
    tc = 8'h03;
    apb_x(1, IDX_OTP_TRIP, 32'h03);
    temp_send(8'hFF);
    apb_x(1, IDX_IRQ_STATUS, 32'h7);
    apb_x(0, IDX_IRQ_STATUS, 0);
    chk("status clear", rd, 0);
    temp_send(8'h00);
    apb_x(0, IDX_IRQ_STATUS, 0);
    chk("status set", rd, 1);
    chk("irq masked", irq, 0);
    apb_x(1, IDX_IRQ_MASK, 1);
    @(posedge clk_sys_i);
    chk("irq raised", irq, 1);
    apb_x(0, IDX_LIVE_FLAGS, 0);
    chk("live flags", rd, 32'h3);
    apb_x(1, IDX_IRQ_STATUS, 1);
    @(posedge clk_sys_i);
    chk("irq cleared", irq, 0);
    // Unmapped place, then a write to a read-only one
    apb_x(0, 8'h50, 0);
    chk("unmapped err", err, 1);
    chk("unmapped data", rd, 0);
    apb_x(1, IDX_TEMP_READING, 32'hAB);
    apb_x(0, IDX_TEMP_READING, 0);
    chk("read only", rd, 0);
    // Falling overtemp flag and rising switch flag both reach status
    temp_send(8'hFF);
    chk("overtemp fall", ot_flag, exp_ot);
    cs_send(-12'sd1);
    cs_send(12'sd1);
    chk("switch rise", sw_flag, 1);
    apb_x(0, IDX_IRQ_STATUS, 0);
    chk("status events", rd, 32'((1 << IRQ_OT_CLR) | (1 << IRQ_SW_SET)));
    chk("irq still masked", irq, 0);
    close_out();
  end
endmodule
